// *** plp_status_fault_irq_tb_top.sv ***
`timescale 1ns/1ps
module plp_status_fault_irq_tb_top
	import plpsf_pkg::*;
;
	localparam int BL = 40;
	localparam int BS = 20;
	localparam logic [3:0] REV = 4'h9;	// arbitrary revision value

	logic        clk, nrst, ce, ext_pg_i, conv_done, hchk_fail;
	plpsf_cond_s cond, c;
	logic [2:0]  fsm_state;
	logic [12:0] cap_value;
	wire logic   scl, host_low, sda_o, sda_oe, irq_n, pg_blanked;
	wire logic   sleep_req, pin1_sel, ser_sel, force_por, sda_line;
	int          bad_count, total_checks;

	// open-drain data line with pull-up
	assign sda_line = ((sda_oe && !sda_o) || host_low) ? 1'b0 : 1'b1;

	plpsf_top #(.REV_ID(REV), .BLANK_LONG(BL), .BLANK_SHORT(BS)) u_dut (
		.clk(clk), .nrst(nrst), .ce(ce), .scl(scl), .sda(sda_line),
		.sda_drive(sda_o), .sda_oe(sda_oe), .ext_pg(ext_pg_i), .cond(cond),
		.fsm_state(fsm_state), .cap_value(cap_value), .conv_done(conv_done),
		.hchk_fail(hchk_fail), .interrupt_out_low_n(irq_n), .pg_blanked(pg_blanked),
		.sleep_req(sleep_req), .pin1_rail_select(pin1_sel),
		.serial_pins_rail_select(ser_sel), .force_por_req(force_por)
	);

	plpsf_host_model #(.DEV_ADDR(7'h25)) u_host (
		.clk(clk), .sda(sda_line), .scl(scl), .sda_low(host_low)
	);

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ************************************************************
	// checking and closing
	// ************************************************************
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// raw conditions held two cycles, then dropped
	task automatic pulse(input plpsf_cond_s p);
		cond = p;
		cyc(2);
		cond = '0;
		cyc(3);
	endtask

	// blanked power-good must rise between n and n+8 cycles after the pin
	task automatic blank_chk(input int n);
		int cnt;
		cnt = 0;
		ext_pg_i = 1'b1;
		while (pg_blanked !== 1'b1 && cnt < n + 30) begin
			cyc(1);
			cnt++;
		end
		chk_bit("blank not early", 1'b1, cnt >= n);
		chk_bit("blank not late", 1'b1, cnt <= n + 8);
		ext_pg_i = 1'b0;
		cyc(10);
		chk_bit("blank drop", 1'b0, pg_blanked);
	endtask

	// hang guard
	initial begin
		cyc(95000);
		bad_count++;
		$display("Error run time limit expected finish seen hang");
		test_done();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		bad_count = 0;
		total_checks = 0;
		nrst = 1'b0;
		ce = 1'b1;
		ext_pg_i = 1'b0;
		conv_done = 1'b0;
		hchk_fail = 1'b0;
		cond = '0;
		fsm_state = PST_UVPOR;
		cap_value = '0;
		cyc(10);
		nrst = 1'b1;
		cyc(5);
		fsm_state = PST_NORMAL;
		cyc(2);
		// a foreign address is left unanswered
		u_host.probe(7'h26);
		chk_byte("foreign addr", 8'h01, u_host.nak_cnt[7:0]);
		u_host.rd(8'h17, 4);
		chk_byte("unmapped", 8'h00, u_host.rbuf[0]);
		chk_byte("rsvd", RSVD_RST, u_host.rbuf[1]);
		chk_byte("mcfg4", {REV, MCFG4_LO_RST}, u_host.rbuf[2]);
		chk_byte("mcfg5", MCFG5_RST, u_host.rbuf[3]);
		u_host.rd(REG_MASK1, 3);
		for (int k = 0; k < 3; k++) chk_byte("mask", MASK_RST, u_host.rbuf[k]);
		u_host.rd(REG_STAT0, 4);
		chk_byte("stat0", {5'h00, PST_NORMAL}, u_host.rbuf[0]);
		for (int k = 1; k < 4; k++) chk_byte("stat", 8'h00, u_host.rbuf[k]);
		chk_bit("irq idle", 1'b1, irq_n);
		$display("test reset done");
		// write lock and the master five fields
		u_host.wr(REG_UNLOCK, 8'h00);
		u_host.wr(REG_MCFG5, 8'h80);
		u_host.rd(REG_MCFG5, 1);
		chk_byte("locked", 8'h00, u_host.rbuf[0]);
		u_host.wr(REG_UNLOCK, UNLOCK_KEY);
		u_host.wr(REG_MCFG5, 8'hb0);
		cyc(3);
		chk_bit("sleep", 1'b1, sleep_req);
		chk_bit("pin1 rail", 1'b1, pin1_sel);
		chk_bit("serial rail", 1'b1, ser_sel);
		u_host.wr(REG_MCFG5, 8'h20);
		u_host.rd(REG_MCFG5, 1);
		chk_byte("mcfg5 rb", 8'h20, u_host.rbuf[0]);
		chk_bit("no sleep", 1'b0, sleep_req);
		chk_bit("pin1 rail", 1'b1, pin1_sel);
		chk_bit("serial rail", 1'b0, ser_sel);
		$display("test config done");
		blank_chk(BL);
		u_host.wr(REG_MCFG4, 8'h08);
		blank_chk(BS);
		$display("test blank done");
		// every raw condition at once in normal state
		u_host.wr(REG_MASK1, 8'h00);
		// status registers ignore writes, stat3 below must stay at its flags
		u_host.wr(REG_STAT3, 8'hff);
		cond = '1;
		cyc(3);
		chk_bit("por req", 1'b1, force_por);
		cond = '0;
		cyc(3);
		chk_bit("irq set", 1'b0, irq_n);
		u_host.rd(REG_STAT1, 3);
		chk_byte("stat1", 8'hff, u_host.rbuf[0]);
		chk_byte("stat2", 8'hfe, u_host.rbuf[1]);
		chk_byte("stat3", 8'hf1, u_host.rbuf[2]);
		u_host.rd(REG_STAT1, 3);
		for (int k = 0; k < 3; k++) chk_byte("cleared", 8'h00, u_host.rbuf[k]);
		chk_bit("irq clear", 1'b1, irq_n);
		// condition still present across a read
		cond.input_overvoltage_flag = 1'b1;
		cyc(3);
		u_host.rd(REG_STAT1, 1);
		chk_byte("ov held", 8'h88, u_host.rbuf[0]);
		cond = '0;
		u_host.rd(REG_STAT1, 1);
		chk_byte("ov latched", 8'h88, u_host.rbuf[0]);
		u_host.rd(REG_STAT1, 1);
		chk_byte("ov gone", 8'h00, u_host.rbuf[0]);
		c = '0;
		c.input_undervoltage_second = 1'b1;
		pulse(c);
		u_host.rd(REG_STAT1, 2);
		chk_byte("summary", 8'h08, u_host.rbuf[0]);
		chk_byte("uv second", 8'h10, u_host.rbuf[1]);
		// a low clock enable freezes the flags, so the pulse is lost
		ce = 1'b0;
		c = '0;
		c.fuse_current_alert = 1'b1;
		pulse(c);
		ce = 1'b1;
		u_host.rd(REG_STAT2, 1);
		chk_byte("frozen", 8'h00, u_host.rbuf[0]);
		$display("test flags done");
		// bootstrap mask position, conversion and health check flags
		u_host.wr(REG_MASK3, 8'hfe);
		c = '0;
		c.bootstrap_fail_flag = 1'b1;
		pulse(c);
		chk_bit("boot irq", 1'b0, irq_n);
		u_host.rd(REG_STAT3, 1);
		chk_byte("boot", 8'h01, u_host.rbuf[0]);
		chk_bit("boot irq off", 1'b1, irq_n);
		u_host.wr(REG_MASK3, 8'hef);
		pulse(c);
		conv_done = 1'b1;
		cyc(1);
		conv_done = 1'b0;
		hchk_fail = 1'b1;
		cyc(1);
		hchk_fail = 1'b0;
		cyc(3);
		chk_bit("boot masked", 1'b1, irq_n);
		u_host.rd(REG_STAT3, 1);
		chk_byte("stat3 ev", 8'h0d, u_host.rbuf[0]);
		$display("test mask done");
		// capture on health check, supplement behaviour
		cap_value = 13'h1a5b;
		fsm_state = PST_HCHK;
		cyc(2);
		fsm_state = PST_SUPP;
		c = '0;
		c.storage_powergood_flag = 1'b1;
		c.supplement_input_uv_flag = 1'b1;
		cond = c;
		cyc(3);
		chk_bit("supp por", 1'b1, force_por);
		cond = '0;
		cyc(2);
		u_host.rd(REG_STAT0, 4);
		chk_byte("stat0", 8'hd4, u_host.rbuf[0]);
		chk_byte("stat2", 8'h01, u_host.rbuf[2]);
		chk_byte("backup", 8'h02, u_host.rbuf[3]);
		fsm_state = PST_NORMAL;
		u_host.rd(REG_STAT3, 1);
		chk_byte("backup left", 8'h02, u_host.rbuf[0]);
		u_host.rd(REG_STAT3, 1);
		chk_byte("backup gone", 8'h00, u_host.rbuf[0]);
		chk_byte("nacks", 8'h01, u_host.nak_cnt[7:0]);
		$display("test state done");
		test_done();
	end
endmodule

// *** plpsf_host_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// host controller on the two-wire bus
// ************************************************************
module plpsf_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h25
) (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	logic [7:0] rbuf [0:3];
	int         nak_cnt;

	// bus idle: clock high, data released to the pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		nak_cnt = 0;
	end

	// one bus phase, well above the minimum of 8 clocks
	task automatic half();
		repeat (20) @(negedge clk);
	endtask

	// start or repeated start: data falls while clock is high
	task automatic start();
		sda_low = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b1;
		half();
		scl = 1'b0;
		half();
	endtask

	// stop: data rises while clock is high
	task automatic stop();
		sda_low = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b0;
		half();
	endtask

	// data set in clock low, sampled at the end of clock high
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		half();
		scl = 1'b1;
		half();
		r = sda;
		scl = 1'b0;
		half();
	endtask

	// msb first, then the device acknowledge bit
	task automatic tx_byte(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		if (r !== 1'b0) begin
			nak_cnt++;
		end
	endtask

	// last byte is ended with a not-acknowledge
	task automatic rx_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask

	// address byte alone, a foreign address must not be acknowledged
	task automatic probe(input logic [6:0] a);
		start();
		tx_byte({a, 1'b0});
		stop();
	endtask

	// pointer byte first, then one data byte
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		start();
		tx_byte({DEV_ADDR, 1'b0});
		tx_byte(ptr);
		tx_byte(d);
		stop();
	endtask

	// set pointer, repeated start, then n auto-increment bytes
	task automatic rd(input logic [7:0] ptr, input int n);
		start();
		tx_byte({DEV_ADDR, 1'b0});
		tx_byte(ptr);
		start();
		tx_byte({DEV_ADDR, 1'b1});
		for (int k = 0; k < n; k++) begin
			rx_byte(k == n - 1, rbuf[k]);
		end
		stop();
	endtask
endmodule

// *** plpsf_pkg.sv ***
package plpsf_pkg;

	// ************************************************************
	// register offsets and reset values
	// ************************************************************
	localparam logic [7:0] REG_UNLOCK  = 8'h0a;
	localparam logic [7:0] REG_RSVD    = 8'h18;
	localparam logic [7:0] REG_MCFG4   = 8'h19;
	localparam logic [7:0] REG_MCFG5   = 8'h1a;
	localparam logic [7:0] REG_MASK1   = 8'h27;
	localparam logic [7:0] REG_MASK2   = 8'h28;
	localparam logic [7:0] REG_MASK3   = 8'h29;
	localparam logic [7:0] REG_STAT0   = 8'he0;
	localparam logic [7:0] REG_STAT1   = 8'he1;
	localparam logic [7:0] REG_STAT2   = 8'he2;
	localparam logic [7:0] REG_STAT3   = 8'he3;
	localparam logic [7:0] UNLOCK_KEY  = 8'haa;
	localparam logic [7:0] UNLOCK_RST  = 8'haa;
	localparam logic [7:0] RSVD_RST    = 8'h00;
	localparam logic [3:0] MCFG4_LO_RST = 4'h3;
	localparam logic [7:0] MCFG5_RST   = 8'h00;
	localparam logic [7:0] MASK_RST    = 8'hff;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BLANK_SEL_BIT   = 3;
	localparam int SLEEP_BIT       = 7;
	localparam int PIN1_RAIL_BIT   = 5;
	localparam int SERIAL_RAIL_BIT = 4;
	localparam int CAP_HI_LSB      = 3;
	localparam int CAP_HI_MSB      = 7;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_KHZ        = 125000;
	localparam int BLANK_LONG_MS  = 40;
	localparam int BLANK_SHORT_MS = 20;
	localparam int BLANK_LONG_CYC  = BLANK_LONG_MS * CLK_KHZ;
	localparam int BLANK_SHORT_CYC = BLANK_SHORT_MS * CLK_KHZ;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		PST_UVPOR  = 3'b000,
		PST_SOFT   = 3'b001,
		PST_NORMAL = 3'b010,
		PST_HCHK   = 3'b011,
		PST_SUPP   = 3'b100,
		PST_SHUT1  = 3'b101,
		PST_SHUT2  = 3'b110,
		PST_NA     = 3'b111
	} plpsf_pst_e;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b000,
		BUS_ADDR = 3'b001,
		BUS_AACK = 3'b010,
		BUS_WR   = 3'b011,
		BUS_WACK = 3'b100,
		BUS_RD   = 3'b101,
		BUS_RACK = 3'b110
	} plpsf_bus_e;

	// raw comparator levels, already on this clock
	typedef struct packed {
		logic input_overvoltage_flag;
		logic temp_trip_flag;
		logic temp_powerdown_flag;
		logic temp_warning_flag;
		logic input_overvoltage_second;
		logic fuse_not_good_flag;
		logic fuse_input_loss_flag;
		logic fuse_current_alert;
		logic fuse_overcurrent_trip;
		logic aux_regulator_uv_flag;
		logic input_undervoltage_second;
		logic storage_undervoltage_flag;
		logic storage_overvoltage_flag;
		logic storage_powergood_flag;
		logic supplement_input_uv_flag;
		logic supplement_current_trip;
		logic supplement_current_alert;
		logic supplement_output_uv_flag;
		logic compensation_short_flag;
		logic bootstrap_fail_flag;
	} plpsf_cond_s;

endpackage

// *** plpsf_top.sv ***
`timescale 1ns/1ps
module plpsf_top
	import plpsf_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR   = 7'h25,
	parameter logic [3:0] REV_ID     = 4'h5,	// arbitrary revision value
	parameter int         BLANK_LONG  = BLANK_LONG_CYC,
	parameter int         BLANK_SHORT = BLANK_SHORT_CYC
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        scl,
	input  wire logic        sda,
	output logic             sda_drive,
	output logic             sda_oe,
	input  wire logic        ext_pg,
	input  wire plpsf_cond_s cond,
	input  wire logic [2:0]  fsm_state,
	input  wire logic [12:0] cap_value,
	input  wire logic        conv_done,
	input  wire logic        hchk_fail,
	output logic             interrupt_out_low_n,
	output logic             pg_blanked,
	output logic             sleep_req,
	output logic             pin1_rail_select,
	output logic             serial_pins_rail_select,
	output logic             force_por_req
);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [2:0] scl_s, sda_s, pg_s;
	logic       scl_f, sda_f, pg_f, scl_q, sda_q;

	// three stages, a change counts when the last two agree
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			pg_s  <= 3'h0;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			pg_f  <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce) begin
			scl_s <= {scl_s[1:0], scl};
			sda_s <= {sda_s[1:0], sda};
			pg_s  <= {pg_s[1:0], ext_pg};
			if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
			if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
			if (pg_s[1] == pg_s[2]) pg_f <= pg_s[2];
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise  = scl_f & ~scl_q;
	assign scl_fall  = ~scl_f & scl_q;
	assign bus_start = scl_f & scl_q & sda_q & ~sda_f;
	assign bus_stop  = scl_f & scl_q & ~sda_q & sda_f;

	// ************************************************************
	// serial bus slave
	// ************************************************************
	plpsf_bus_e  bus_r;
	logic [3:0]  cnt_r;
	logic [7:0]  sh_r, ptr_r, rdata;
	logic        rw_r, first_r, nack_r, wr_pulse, rd_done;
	logic [7:0]  wr_addr;

	assign sda_drive = 1'b0;	// open drain, only the enable moves

	// start, address, pointer, data, ack phases
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bus_r    <= BUS_IDLE;
			cnt_r    <= 4'h0;
			sh_r     <= 8'h00;
			ptr_r    <= 8'h00;
			rw_r     <= 1'b0;
			first_r  <= 1'b0;
			nack_r   <= 1'b0;
			sda_oe   <= 1'b0;
			wr_pulse <= 1'b0;
			wr_addr  <= 8'h00;
			rd_done  <= 1'b0;
		end else if (ce) begin
			wr_pulse <= 1'b0;
			rd_done  <= 1'b0;
			if (bus_start) begin
				bus_r  <= BUS_ADDR;
				cnt_r  <= 4'h0;
				sda_oe <= 1'b0;
			end else if (bus_stop) begin
				bus_r  <= BUS_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (bus_r == BUS_ADDR || bus_r == BUS_WR) begin
					sh_r  <= {sh_r[6:0], sda_f};
					cnt_r <= cnt_r + 4'h1;
				end
				if (bus_r == BUS_RACK) nack_r <= sda_f;
			end else if (scl_fall) begin
				unique case (bus_r)
					BUS_IDLE: ;
					BUS_ADDR: if (cnt_r == 4'h8) begin
						if (sh_r[7:1] == DEV_ADDR) begin
							bus_r  <= BUS_AACK;
							rw_r   <= sh_r[0];
							sda_oe <= 1'b1;
						end else begin
							bus_r <= BUS_IDLE;
						end
					end
					BUS_AACK: begin
						cnt_r <= 4'h0;
						if (rw_r) begin
							bus_r  <= BUS_RD;
							sh_r   <= rdata;
							sda_oe <= ~rdata[7];
						end else begin
							bus_r   <= BUS_WR;
							first_r <= 1'b1;
							sda_oe  <= 1'b0;
						end
					end
					BUS_WR: if (cnt_r == 4'h8) begin
						bus_r  <= BUS_WACK;
						sda_oe <= 1'b1;
						if (first_r) begin
							ptr_r <= sh_r;
						end else begin
							wr_pulse <= 1'b1;
							wr_addr  <= ptr_r;
							ptr_r    <= ptr_r + 8'h01;
						end
					end
					BUS_WACK: begin
						bus_r   <= BUS_WR;
						cnt_r   <= 4'h0;
						first_r <= 1'b0;
						sda_oe  <= 1'b0;
					end
					BUS_RD: if (cnt_r == 4'h7) begin
						bus_r   <= BUS_RACK;
						sda_oe  <= 1'b0;
						rd_done <= 1'b1;
						ptr_r   <= ptr_r + 8'h01;
					end else begin
						sh_r   <= {sh_r[6:0], 1'b0};
						sda_oe <= ~sh_r[6];
						cnt_r  <= cnt_r + 4'h1;
					end
					BUS_RACK: if (nack_r) begin
						bus_r <= BUS_IDLE;
					end else begin
						bus_r  <= BUS_RD;
						cnt_r  <= 4'h0;
						sh_r   <= rdata;
						sda_oe <= ~rdata[7];
					end
					default: bus_r <= BUS_IDLE;
				endcase
			end
		end
	end

	// ************************************************************
	// configuration registers
	// ************************************************************
	logic [7:0] unlock_r, rsvd_r, mcfg4_r, mcfg5_r, mask1_r, mask2_r, mask3_r;
	logic       wr_ok;
	logic [7:0] wdata;

	assign wdata = sh_r;
	// the key register itself stays writable so software can unlock
	assign wr_ok = wr_pulse & (unlock_r == UNLOCK_KEY || wr_addr == REG_UNLOCK);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			unlock_r <= UNLOCK_RST;
			rsvd_r   <= RSVD_RST;
			mcfg4_r  <= {REV_ID, MCFG4_LO_RST};
			mcfg5_r  <= MCFG5_RST;
			mask1_r  <= MASK_RST;
			mask2_r  <= MASK_RST;
			mask3_r  <= MASK_RST;
		end else if (ce && wr_ok) begin
			if (wr_addr == REG_UNLOCK) unlock_r <= wdata;
			if (wr_addr == REG_RSVD) rsvd_r <= wdata;
			if (wr_addr == REG_MCFG4) mcfg4_r <= wdata;
			if (wr_addr == REG_MCFG5) mcfg5_r <= wdata;
			if (wr_addr == REG_MASK1) mask1_r <= wdata;
			if (wr_addr == REG_MASK2) mask2_r <= wdata;
			if (wr_addr == REG_MASK3) mask3_r <= wdata;
		end
	end

	// configuration driven outputs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sleep_req               <= 1'b0;
			pin1_rail_select        <= 1'b0;
			serial_pins_rail_select <= 1'b0;
		end else if (ce) begin
			sleep_req               <= mcfg5_r[SLEEP_BIT];
			pin1_rail_select        <= mcfg5_r[PIN1_RAIL_BIT];
			serial_pins_rail_select <= mcfg5_r[SERIAL_RAIL_BIT];
		end
	end

	// ************************************************************
	// power-good blanking
	// ************************************************************
	logic [22:0] blank_r;
	logic [22:0] blank_end;
	assign blank_end = mcfg4_r[BLANK_SEL_BIT] ? 23'(BLANK_SHORT - 1) : 23'(BLANK_LONG - 1);

	// good only after the pin has stayed high for the blanking time
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			blank_r    <= 23'h0;
			pg_blanked <= 1'b0;
		end else if (ce) begin
			if (!pg_f) begin
				blank_r    <= 23'h0;
				pg_blanked <= 1'b0;
			end else if (blank_r == blank_end) begin
				pg_blanked <= 1'b1;
			end else begin
				blank_r <= blank_r + 23'h1;
			end
		end
	end

	// ************************************************************
	// status flags
	// ************************************************************
	logic [7:0] raw1, raw2, raw3, st1_r, st2_r, st3_r, clr1, clr2, clr3;
	logic [4:0] cap_hi_r;
	logic [2:0] state_q;
	logic       in_supp, pg_window;

	assign in_supp   = fsm_state == PST_SUPP;
	assign pg_window = fsm_state == PST_NORMAL || fsm_state == PST_HCHK;

	assign raw1 = {cond.input_overvoltage_flag, cond.temp_trip_flag,
		cond.temp_powerdown_flag, cond.temp_warning_flag,
		cond.input_undervoltage_second | cond.input_overvoltage_second
			| cond.input_overvoltage_flag,
		cond.input_overvoltage_second, cond.fuse_not_good_flag,
		cond.fuse_input_loss_flag};
	assign raw2 = {cond.fuse_current_alert, cond.fuse_overcurrent_trip,
		cond.aux_regulator_uv_flag, cond.input_undervoltage_second,
		cond.storage_undervoltage_flag, cond.storage_overvoltage_flag,
		cond.storage_powergood_flag & pg_window,
		cond.supplement_input_uv_flag & in_supp};
	assign raw3 = {cond.supplement_current_trip, cond.supplement_current_alert,
		cond.supplement_output_uv_flag, cond.compensation_short_flag,
		conv_done, hchk_fail, in_supp,
		cond.bootstrap_fail_flag};

	assign clr1 = {8{rd_done && ptr_r == REG_STAT1 + 8'h01}};
	assign clr2 = {8{rd_done && ptr_r == REG_STAT2 + 8'h01}};
	assign clr3 = {8{rd_done && ptr_r == REG_STAT3 + 8'h01}};

	// latch on condition, clear on read only when it is gone; set wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st1_r <= 8'h00;
			st2_r <= 8'h00;
			st3_r <= 8'h00;
		end else if (ce) begin
			st1_r <= raw1 | (st1_r & ~clr1);
			st2_r <= raw2 | (st2_r & ~clr2);
			st3_r <= raw3 | (st3_r & ~clr3);
		end
	end

	// capacitance snapshot on entry to health check
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q  <= 3'h0;
			cap_hi_r <= 5'h00;
		end else if (ce) begin
			state_q <= fsm_state;
			if (fsm_state == PST_HCHK && state_q != PST_HCHK) cap_hi_r <= cap_value[12:8];
		end
	end

	// interrupt and reset request
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			interrupt_out_low_n <= 1'b1;
			force_por_req       <= 1'b0;
		end else if (ce) begin
			interrupt_out_low_n <= ~|{st1_r & ~mask1_r, st2_r & ~mask2_r,
				st3_r & ~mask3_r};
			force_por_req <= raw2[0] | raw3[7] | raw3[5];
		end
	end

	// ************************************************************
	// read mux
	// ************************************************************
	always_comb begin
		unique case (ptr_r)
			REG_UNLOCK: rdata = unlock_r;
			REG_RSVD:   rdata = rsvd_r;
			REG_MCFG4:  rdata = mcfg4_r;
			REG_MCFG5:  rdata = mcfg5_r;
			REG_MASK1:  rdata = mask1_r;
			REG_MASK2:  rdata = mask2_r;
			REG_MASK3:  rdata = mask3_r;
			REG_STAT0:  rdata = {cap_hi_r, fsm_state};
			REG_STAT1:  rdata = st1_r;
			REG_STAT2:  rdata = st2_r;
			REG_STAT3:  rdata = st3_r;
			default:    rdata = 8'h00;
		endcase
	end

	// ************************************************************
	// checks
	// ************************************************************
	sleep_tie_a: assert property (@(posedge clk) disable iff (!nrst)
		ce |=> sleep_req == $past(mcfg5_r[SLEEP_BIT])) else $error("sleep output wrong");
	flag_latch_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && raw3[4] |=> st3_r[4]) else $error("fault not latched");
	read_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && clr1[0] && !raw1[7] |=> !st1_r[7]) else $error("flag not cleared by read");
	hold_unread_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && st2_r[3] && !clr2[0] |=> st2_r[3]) else $error("flag dropped without read");
	irq_drive_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && (st3_r[0] && !mask3_r[0]) |=> !interrupt_out_low_n) else $error("irq missing");
	summary_or_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && cond.input_undervoltage_second |=> st1_r[3]) else $error("summary not set");
	pg_gate_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && !pg_window && !st2_r[1] |=> !st2_r[1]) else $error("storage pg outside window");
	por_force_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && in_supp && cond.supplement_input_uv_flag |=> force_por_req)
		else $error("no reset request");
	write_lock_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && wr_pulse && wr_addr == REG_MCFG5 && unlock_r != UNLOCK_KEY |=> $stable(mcfg5_r))
		else $error("locked write took effect");
	blank_time_a: assert property (@(posedge clk) disable iff (!nrst)
		$rose(pg_blanked) |-> $past(blank_r) == $past(blank_end)) else $error("blank time wrong");
	cap_snap_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && fsm_state == PST_HCHK && state_q != PST_HCHK |=> cap_hi_r == $past(cap_value[12:8]))
		else $error("capacitance not refreshed");

	read_done_c: cover property (@(posedge clk) disable iff (!nrst) rd_done);
	write_ok_c: cover property (@(posedge clk) disable iff (!nrst) wr_ok);
	irq_low_c: cover property (@(posedge clk) disable iff (!nrst) $fell(interrupt_out_low_n));
	pg_good_c: cover property (@(posedge clk) disable iff (!nrst) $rose(pg_blanked));

endmodule
